// ==== logic/cor_defs.vh ====
`ifndef COR_DEFS_VH
`define COR_DEFS_VH

// Register offsets on the serial control interface
`define COR_ADDR_XO_HIGH      8'h10
`define COR_ADDR_XO_LOW       8'h11
`define COR_ADDR_DRIVE        8'h14
`define COR_ADDR_POLARITY     8'h15
`define COR_ADDR_DIV_HIGH     8'h16
`define COR_ADDR_DIV_LOW      8'h17

// Reset values
`define COR_RST_XO_HIGH       2'h0
`define COR_RST_XO_LOW        8'h80
`define COR_RST_TRISTATE      1'b0
`define COR_RST_SILENCE       1'b0
`define COR_RST_INVERT        1'b0
`define COR_RST_EDGE          2'h0
`define COR_RST_PRESCALE      1'b0
`define COR_RST_DIV_SPARE     4'h0
`define COR_RST_DIV_HIGH      1'b0
`define COR_RST_DIV_LOW       8'h20

// Field positions
`define COR_XO_HIGH_MSB       1
`define COR_XO_HIGH_LSB       0
`define COR_BIT_TRISTATE      2
`define COR_BIT_SILENCE       1
`define COR_BIT_INV_SECOND    5
`define COR_BIT_INV_FIRST     4
`define COR_EDGE_MSB          7
`define COR_EDGE_LSB          6
`define COR_BIT_PRESCALE      5
`define COR_DIV_SPARE_MSB     4
`define COR_DIV_SPARE_LSB     1
`define COR_BIT_DIV8          0

// Encodings
`define COR_EDGE_FAST         2'h0
`define COR_EDGE_SLOW         2'h2
`define COR_PRESC_DIV4        3'h3
`define COR_PRESC_DIV5        3'h4
`define COR_READ_ZERO         8'h00

`endif

// ==== logic/cor_out_div.v ====
`timescale 1ns/1ps
`include "cor_defs.vh"

// Output prescaler (4 or 5) followed by the integer divider (code plus one)
module cor_out_div
#(
	parameter DIV_W = 9
)
(
	input  wire             clk_sys,
	input  wire             rst,
	input  wire             pll_tick,
	input  wire             prescale_five,
	input  wire [DIV_W-1:0] divide_code,
	output wire             div_clk
);

	reg [2:0]       presc_cnt_r;
	reg [DIV_W-1:0] div_cnt_r;
	reg             div_clk_r;
	wire            presc_tick;
	wire [2:0]      presc_last;
	wire [DIV_W:0]  ratio;
	wire [DIV_W-1:0] half;

	// Prescaler terminal count picks 4 or 5
	assign presc_last = prescale_five ? `COR_PRESC_DIV5 : `COR_PRESC_DIV4;
	assign presc_tick = pll_tick && (presc_cnt_r >= presc_last);

	// Ratio is the code plus one; high for the first half of the period
	assign ratio = {1'b0, divide_code} + {{DIV_W{1'b0}}, 1'b1};
	assign half  = ratio[DIV_W:1];

	// Prescaler counter; a shrunk terminal count wraps on the next tick
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			presc_cnt_r <= 3'h0;
		else if (presc_tick)
			presc_cnt_r <= 3'h0;
		else if (pll_tick)
			presc_cnt_r <= presc_cnt_r + 3'h1;
	end

	// Divider counter; a code change moves the end of the current period at once,
	// and a count already past the new end wraps on the next prescaler tick
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			div_cnt_r <= {DIV_W{1'b0}};
			div_clk_r <= 1'b0;
		end
		else if (presc_tick)
		begin
			if (div_cnt_r >= divide_code)
				div_cnt_r <= {DIV_W{1'b0}};
			else
				div_cnt_r <= div_cnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
			div_clk_r <= (div_cnt_r >= divide_code) ||
				((div_cnt_r + {{(DIV_W-1){1'b0}}, 1'b1}) < half);
		end
	end

	assign div_clk = div_clk_r;

endmodule // cor_out_div

// ==== logic/cor_regs.v ====
// Summary of operation
// - Offset bits 9:8 sit in the first register, bits 7:0 in the next one.
// - The first output floats while tristate bit 2 is one or reset is asserted, else is driven.
// - Bit 1 silences the output channel while set; it resets to zero.
// - Bit 5 inverts the second output and bit 4 the first, both reset zero.
// - Edge speed code 0x0 selects fast edges and 0x2 slow, reset fast.
// - The prescaler divides by four when bit 5 is zero and by five if one.
// - The 9-bit divide value is upper register bit 0 over the lower byte.
// - Host codes run 5 to 255 and the divider divides by the code plus one.
`timescale 1ns/1ps
`include "cor_defs.vh"

module cor_regs
#(
	parameter ADDR_W   = 8,
	parameter DATA_W   = 8,
	parameter DIV_W    = 9,
	parameter OFFSET_W = 10
)
(
	input  wire                clk_sys,
	input  wire                rst,
	input  wire [ADDR_W-1:0]   reg_addr,
	input  wire [DATA_W-1:0]   reg_wdata,
	input  wire                reg_wr,
	input  wire                reg_rd,
	output wire [DATA_W-1:0]   reg_rdata,
	output wire                reg_rvalid,
	input  wire                pll_tick,
	output wire [OFFSET_W-1:0] xo_margin_offset,
	output wire [1:0]          edge_speed_select,
	output wire                edge_slow,
	output wire                output_prescaler_select,
	output wire [DIV_W-1:0]    output_divide_value,
	output wire                clk_out_first,
	output wire                clk_out_first_oe,
	output wire                clk_out_second,
	output wire                clk_out_second_oe
);

	// Stored register fields
	reg [1:0]          xo_high_r;
	reg [7:0]          xo_low_r;
	reg                primary_output_tristate_r;
	reg                output_silence_r;
	reg                second_output_invert_r;
	reg                first_output_invert_r;
	reg [1:0]          edge_speed_select_r;
	reg                edge_slow_r;
	reg                prescale_r;
	reg [3:0]          div_spare_r;
	reg                div_high_r;
	reg [7:0]          div_low_r;
	reg [DIV_W-1:0]    div_applied_r;
	reg [DATA_W-1:0]   rdata_r;
	reg                rvalid_r;
	reg                out_first_r;
	reg                out_second_r;
	reg                out_first_oe_r;
	reg [DATA_W-1:0]   rdata_nxt;

	wire               div_clk;
	wire               chan_clk;

	// Address match shared by write decode and read mux
	function hit;
		input [ADDR_W-1:0] addr;
		input [ADDR_W-1:0] target;
		begin
			hit = (addr == target);
		end
	endfunction

	// Register writes; reserved bits are dropped except the spare
	// divider bits, which store like ordinary bits
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			xo_high_r                 <= `COR_RST_XO_HIGH;
			xo_low_r                  <= `COR_RST_XO_LOW;
			primary_output_tristate_r <= `COR_RST_TRISTATE;
			output_silence_r          <= `COR_RST_SILENCE;
			second_output_invert_r    <= `COR_RST_INVERT;
			first_output_invert_r     <= `COR_RST_INVERT;
			edge_speed_select_r       <= `COR_RST_EDGE;
			edge_slow_r               <= (`COR_RST_EDGE == `COR_EDGE_SLOW);
			prescale_r                <= `COR_RST_PRESCALE;
			div_spare_r               <= `COR_RST_DIV_SPARE;
			div_high_r                <= `COR_RST_DIV_HIGH;
			div_low_r                 <= `COR_RST_DIV_LOW;
		end
		else if (reg_wr)
		begin
			if (hit(reg_addr, `COR_ADDR_XO_HIGH))
				xo_high_r <= reg_wdata[`COR_XO_HIGH_MSB:`COR_XO_HIGH_LSB];
			if (hit(reg_addr, `COR_ADDR_XO_LOW))
				xo_low_r <= reg_wdata;
			if (hit(reg_addr, `COR_ADDR_DRIVE))
			begin
				primary_output_tristate_r <= reg_wdata[`COR_BIT_TRISTATE];
				output_silence_r <= reg_wdata[`COR_BIT_SILENCE];
			end
			if (hit(reg_addr, `COR_ADDR_POLARITY))
			begin
				second_output_invert_r <= reg_wdata[`COR_BIT_INV_SECOND];
				first_output_invert_r  <= reg_wdata[`COR_BIT_INV_FIRST];
			end
			if (hit(reg_addr, `COR_ADDR_DIV_HIGH))
			begin
				edge_speed_select_r <= reg_wdata[`COR_EDGE_MSB:`COR_EDGE_LSB];
				// Decoded at write time so the pin comes straight off a flop
				edge_slow_r <= (reg_wdata[`COR_EDGE_MSB:`COR_EDGE_LSB] ==
					`COR_EDGE_SLOW);
				prescale_r <= reg_wdata[`COR_BIT_PRESCALE];
				div_spare_r <=
					reg_wdata[`COR_DIV_SPARE_MSB:`COR_DIV_SPARE_LSB];
				div_high_r <= reg_wdata[`COR_BIT_DIV8];
			end
			if (hit(reg_addr, `COR_ADDR_DIV_LOW))
				div_low_r <= reg_wdata;
		end
	end

	// Divider load: the lower byte only stages, so a host that writes
	// low then high never exposes a half-updated ratio
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			div_applied_r <= {`COR_RST_DIV_HIGH, `COR_RST_DIV_LOW};
		else if (reg_wr && hit(reg_addr, `COR_ADDR_DIV_HIGH))
			div_applied_r <= {reg_wdata[`COR_BIT_DIV8], div_low_r};
	end

	// Read mux; unmapped offsets and reserved bits read zero, except the spare divider bits
	always @*
	begin
		rdata_nxt = `COR_READ_ZERO;
		if (hit(reg_addr, `COR_ADDR_XO_HIGH))
			rdata_nxt[`COR_XO_HIGH_MSB:`COR_XO_HIGH_LSB] = xo_high_r;
		else if (hit(reg_addr, `COR_ADDR_XO_LOW))
			rdata_nxt = xo_low_r;
		else if (hit(reg_addr, `COR_ADDR_DRIVE))
		begin
			rdata_nxt[`COR_BIT_TRISTATE] = primary_output_tristate_r;
			rdata_nxt[`COR_BIT_SILENCE]  = output_silence_r;
		end
		else if (hit(reg_addr, `COR_ADDR_POLARITY))
		begin
			rdata_nxt[`COR_BIT_INV_SECOND] = second_output_invert_r;
			rdata_nxt[`COR_BIT_INV_FIRST]  = first_output_invert_r;
		end
		else if (hit(reg_addr, `COR_ADDR_DIV_HIGH))
		begin
			rdata_nxt[`COR_EDGE_MSB:`COR_EDGE_LSB] = edge_speed_select_r;
			rdata_nxt[`COR_BIT_PRESCALE] = prescale_r;
			rdata_nxt[`COR_DIV_SPARE_MSB:`COR_DIV_SPARE_LSB] = div_spare_r;
			rdata_nxt[`COR_BIT_DIV8] = div_high_r;
		end
		else if (hit(reg_addr, `COR_ADDR_DIV_LOW))
			rdata_nxt = div_low_r;
	end

	// Read data registered; valid pulses one cycle after the strobe
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			rdata_r  <= `COR_READ_ZERO;
			rvalid_r <= 1'b0;
		end
		else
		begin
			rvalid_r <= reg_rd;
			if (reg_rd)
				rdata_r <= rdata_nxt;
		end
	end

	// Output clock divider runs from the applied value only
	cor_out_div
	#(
		.DIV_W (DIV_W)
	)
	u_out_div
	(
		.clk_sys       (clk_sys),
		.rst           (rst),
		.pll_tick      (pll_tick),
		.prescale_five (prescale_r),
		.divide_code   (div_applied_r),
		.div_clk       (div_clk)
	);

	// Silence forces the channel low before inversion, so an inverted
	// output parks high while muted
	assign chan_clk = div_clk & ~output_silence_r;

	// Output stage registered to keep the pins glitch free
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			out_first_r    <= 1'b0;
			out_second_r   <= 1'b0;
			out_first_oe_r <= 1'b0;
		end
		else
		begin
			out_first_r    <= chan_clk ^ first_output_invert_r;
			out_second_r   <= chan_clk ^ second_output_invert_r;
			out_first_oe_r <= ~primary_output_tristate_r;
		end
	end

	assign reg_rdata               = rdata_r;
	assign reg_rvalid              = rvalid_r;
	assign xo_margin_offset        = {xo_high_r, xo_low_r};
	assign edge_speed_select       = edge_speed_select_r;
	assign edge_slow               = edge_slow_r;
	assign output_prescaler_select = prescale_r;
	assign output_divide_value     = div_applied_r;
	assign clk_out_first           = out_first_r;
	assign clk_out_first_oe        = out_first_oe_r;
	assign clk_out_second          = out_second_r;
	assign clk_out_second_oe       = 1'b1; // Tristate lives elsewhere

endmodule // cor_regs

// ==== tb/cor_regs_checker.sv ====
`timescale 1ns/1ps
// Port-level properties of the register bank
module cor_regs_checker
(
	input wire       clk_sys,
	input wire       rst,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_wr,
	input wire       reg_rd,
	input wire [7:0] reg_rdata,
	input wire       reg_rvalid,
	input wire [9:0] xo_margin_offset,
	input wire [1:0] edge_speed_select,
	input wire       edge_slow,
	input wire       output_prescaler_select,
	input wire [8:0] output_divide_value,
	input wire       clk_out_first_oe
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Write strobes per offset
	wire w10 = reg_wr && reg_addr == 8'h10;
	wire w11 = reg_wr && reg_addr == 8'h11;
	wire w14 = reg_wr && reg_addr == 8'h14;
	wire w16 = reg_wr && reg_addr == 8'h16;
	property p_rvalid; reg_rd |=> reg_rvalid; endproperty
	a_rvalid: assert property (p_rvalid) else $error("read not answered");
	property p_rsv;
		reg_rd && reg_addr == 8'h14 |=>
			reg_rdata[7:3] == 5'h00 && !reg_rdata[0];
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits set");
	property p_xo_lo;
		w11 |=> xo_margin_offset[7:0] == $past(reg_wdata);
	endproperty
	a_xo_lo: assert property (p_xo_lo) else $error("offset low wrong");
	property p_xo_hi;
		w10 |=> xo_margin_offset[9:8] == $past(reg_wdata[1:0]);
	endproperty
	a_xo_hi: assert property (p_xo_hi) else $error("offset high wrong");
	// Output enable follows the tristate bit two edges later
	property p_hiz;
		w14 |-> ##2 clk_out_first_oe == !$past(reg_wdata[2], 2);
	endproperty
	a_hiz: assert property (p_hiz) else $error("enable wrong");
	property p_slow; edge_slow == (edge_speed_select == 2'h2); endproperty
	a_slow: assert property (p_slow) else $error("edge decode wrong");
	property p_ctl;
		w16 |=> edge_speed_select == $past(reg_wdata[7:6]) &&
			output_prescaler_select == $past(reg_wdata[5]);
	endproperty
	a_ctl: assert property (p_ctl) else $error("control wrong");
	property p_div8;
		w16 |=> output_divide_value[8] == $past(reg_wdata[0]);
	endproperty
	a_div8: assert property (p_div8) else $error("divide bit wrong");
	// A lone low-byte write must not reach the divider
	property p_hold; !w16 |=> $stable(output_divide_value); endproperty
	a_hold: assert property (p_hold) else $error("divide changed");
	c_load: cover property (w16);
	c_slow: cover property (edge_slow);
	c_hiz: cover property (!clk_out_first_oe);
endmodule // cor_regs_checker

bind cor_regs cor_regs_checker i_chk (.clk_sys(clk_sys), .rst(rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.xo_margin_offset(xo_margin_offset), .edge_slow(edge_slow),
	.edge_speed_select(edge_speed_select),
	.output_prescaler_select(output_prescaler_select),
	.output_divide_value(output_divide_value),
	.clk_out_first_oe(clk_out_first_oe));

// ==== tb/cor_host_model.sv ====
`timescale 1ns/1ps
// Host behind the serial decoder: one strobe per access
module cor_host_model
(
	input  wire        clk_sys,
	input  wire [7:0]  reg_rdata,
	input  wire        reg_rvalid,
	output logic [7:0] reg_addr = 8'h00,
	output logic [7:0] reg_wdata = 8'h00,
	output logic       reg_wr = 1'b0,
	output logic       reg_rd = 1'b0
);
	// Bus is inverted on release so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	// Missing answer yields unknown data
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rvalid ? reg_rdata : 8'hxx;
	endtask
	// Low byte first, then the byte that commits the value
	task automatic div(input logic [7:0] hi, input logic [8:0] c);
		wr(8'h17, c[7:0]);
		wr(8'h16, {hi[7:1], c[8]});
	endtask
endmodule // cor_host_model

// ==== tb/tb_clock_output_config_regs.sv ====
`timescale 1ns/1ps
module tb_clock_output_config_regs;
	logic       clk_sys = 1'b0;
	logic       rst = 1'b1;
	logic       pll_tick = 1'b0;
	wire  [7:0] a, wd, rdat;
	wire        wr, rd, rv, slow, pre, c1, oe1, c2, oe2;
	wire  [9:0] xo;
	wire  [1:0] es;
	wire  [8:0] dv;
	int         error_cnt = 0;
	int         samples_checked = 0;
	int         cyc = 0;
	logic [7:0] ra [6] = '{8'h10, 8'h11, 8'h14, 8'h15, 8'h16, 8'h17};
	logic [7:0] rv0 [6] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h20};
	logic [7:0] rmk [6] = '{8'h03, 8'hff, 8'h06, 8'h30, 8'hfe, 8'hff};

	cor_regs i_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(a),
		.reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat),
		.reg_rvalid(rv), .pll_tick(pll_tick), .xo_margin_offset(xo),
		.edge_speed_select(es), .edge_slow(slow),
		.output_prescaler_select(pre), .output_divide_value(dv),
		.clk_out_first(c1), .clk_out_first_oe(oe1),
		.clk_out_second(c2), .clk_out_second_oe(oe2));
	cor_host_model i_host (.clk_sys(clk_sys), .reg_rdata(rdat),
		.reg_rvalid(rv), .reg_addr(a), .reg_wdata(wd), .reg_wr(wr),
		.reg_rd(rd));

	// Clock, tick every other cycle, and a hang limit
	initial forever #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
	begin
		pll_tick <= ~pll_tick;
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			error_cnt++;
			report_and_stop();
		end
	end

	// Wide enough for the longest period count in cycles
	task automatic chk(input string n, input logic [15:0] s,
		input logic [15:0] e);
		samples_checked++;
		if (s !== e)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic report_and_stop();
		if (error_cnt == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Reset values, read back and at the outputs
	task automatic t_reset();
		logic [7:0] d;
		for (int i = 0; i < 6; i++)
		begin
			i_host.rd(ra[i], d);
			chk("reset", d, rv0[i]);
		end
		chk("offset", xo, 10'h080);
		chk("divide", dv, 9'h020);
		chk("edge", es, 2'h0);
		chk("oe", oe1, 1'b1);
		chk("oe2", oe2, 1'b1);
		chk("presc", pre, 1'b0);
	endtask

	// All ones but divide bit 8, which would form a reserved code;
	// the high byte goes first so the staged low byte must not apply
	task automatic t_rw();
		logic [7:0] d;
		for (int i = 0; i < 6; i++)
		begin
			i_host.wr(ra[i], (ra[i] == 8'h16) ? 8'hfe : 8'hff);
			i_host.rd(ra[i], d);
			chk("rw", d, rmk[i]);
		end
		i_host.wr(8'h12, 8'hff);
		i_host.rd(8'h12, d);
		chk("unmapped", d, 8'h00);
		chk("offset", xo, 10'h3ff);
		chk("divide", dv, 9'h020);
		chk("oe", oe1, 1'b0);
	endtask

	// Muted channels show only their inversion bits
	task automatic t_mute();
		i_host.wr(8'h14, 8'h02);
		for (int v = 0; v < 4; v++)
		begin
			i_host.wr(8'h15, {2'h0, v[1:0], 4'h0});
			repeat (3) @(posedge clk_sys);
			for (int k = 0; k < 4; k++)
			begin
				@(posedge clk_sys);
				#1;
				chk("first", c1, v[0]);
				chk("second", c2, v[1]);
			end
		end
		i_host.wr(8'h14, 8'h00);
		i_host.wr(8'h15, 8'h00);
	endtask

	// Period of the first output in clk_sys cycles, ticks every 2nd
	task automatic t_div();
		logic [8:0] c [2] = '{9'h005, 9'h0ff};
		logic [1:0] e;
		realtime t;
		for (int i = 0; i < 2; i++)
		begin
			e = i ? 2'h0 : 2'h2;
			i_host.div({e, i[0], 5'h00}, c[i]);
			@(posedge clk_sys);
			#1;
			chk("divide", dv, c[i]);
			chk("slow", slow, e == 2'h2);
			chk("presc", pre, i[0]);
			repeat (2) @(posedge c1);
			t = $realtime;
			@(posedge c1);
			chk("period", int'(($realtime - t) / 50.0),
				2 * (c[i] + 1) * (i ? 5 : 4));
		end
	endtask

	initial
	begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		t_reset();
		t_rw();
		t_mute();
		t_div();
		report_and_stop();
	end
endmodule // tb_clock_output_config_regs
